//--- hw/frr_fault_recovery.sv
// fault recovery, retry/latch-off control and reset output for a supply sequencer
// assumes synchronous comparator flags, a conversion strobe and a slot sequencer outside
// How it works
// - a sequencing overvoltage or undervoltage fault drops every supply enable
// - a sequencing fault stores the failing slot in log byte zero bits 3:0
// - a closed-loop tracking fault clears its channel bit in log byte zero
// - recovery bit 3 low: shut down then restart after the retry delay
// - retry delay code 0..7 gives 20us up to 1.6s
// - recovery bit 3 high: stay off until enable pin toggles or software enable clears
// - slew code selects 800, 400, 200 or 100 V/s tracking ramp
// - a fault counts after 2, 4, 8 or 16 consecutive conversions
// - reset held while sequencing, released a timeout after power-up completes
// - power-up completes when slot 12 inputs pass undervoltage, or when its delay ends if slot 12 has no inputs
// - inputs with a critical fault enable also drive reset
// - reset condition code picks undervoltage, early warning, overvoltage or both
// - reset config bit 2 sets active-high or active-low reset
// - reset config bit 3 picks push-pull or open-drain drive
// - reset timeout code 0..7 gives 25us up to 1600ms
// - manual reset pin low asserts the reset output
// - per-input dependency bits make reset follow that input
`timescale 1ns/1ps
module frr_fault_recovery import frr_pkg::*; #(
	parameter int NUM_MON  = 12,
	parameter int TICK_CYC = TICK_NS / CLK_PERIOD_NS
) (
	input  wire logic               ref_clk,
	input  wire logic               rstn,
	input  wire logic               regWrEn,
	input  wire logic [7:0]         regAddr,
	input  wire logic [7:0]         regWrData,
	output logic      [7:0]         regRdData,
	input  wire logic               hwEnable,
	input  wire logic [NUM_MON-1:0] monUnder,
	input  wire logic [NUM_MON-1:0] monOver,
	input  wire logic [NUM_MON-1:0] monWarn,
	input  wire logic               convDone,
	input  wire logic [NUM_MON-1:0] monCritEn,
	input  wire logic [NUM_MON-1:0] slot12Assign,
	input  wire logic               slot12DelayDone,
	input  wire logic               seqFault,
	input  wire logic [3:0]         seqSlot,
	input  wire logic [3:0]         trackFault,
	input  wire logic [3:0]         trackLoopEn,
	input  wire logic               mrSelect,
	input  wire logic               generalPinFour,
	output logic                    enableGate,
	output logic                    latchedOff,
	output logic                    resetPinOut,
	output logic                    resetPinOe,
	output logic                    logStart,
	output logic      [7:0]         logByteZero,
	output logic                    trackRampStep
);
	// ****************************************
	// parameter checks
	// ****************************************
	if (NUM_MON < 1 || NUM_MON > 12) begin : g_bad_mon
		$error("NUM_MON must be 1 to 12");
	end
	if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_bad_tick
		$error("TICK_CYC must be 1 to 65535");
	end
	// ****************************************
	// registers
	// ****************************************
	logic [7:0] rstCfg_reg, depLo_reg, depHi_reg, recov_reg, log0_reg, log0_next, rdData_next;
	logic [1:0] logCtl_reg;
	logic       swDis_reg, hwEnD_reg;
	wire        wrRst  = regWrEn && regAddr == ADDR_RSTCFG;
	wire        wrDepL = regWrEn && regAddr == ADDR_DEPLO;
	wire        wrDepH = regWrEn && regAddr == ADDR_DEPHI;
	wire        wrLog  = regWrEn && regAddr == ADDR_LOGCTL;
	wire        wrSw   = regWrEn && regAddr == ADDR_SWEN;
	wire        wrRec  = regWrEn && regAddr == ADDR_RECOV;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rstCfg_reg <= RST_RSTCFG;
			depLo_reg  <= RST_DEP;
			depHi_reg  <= RST_DEP;
			logCtl_reg <= RST_LOGCTL;
			swDis_reg  <= RST_SWDIS;
			recov_reg  <= RST_RECOV;
			hwEnD_reg  <= 1'b0;
		end else begin
			if (wrRst) rstCfg_reg <= regWrData;
			if (wrDepL) depLo_reg <= regWrData;
			if (wrDepH) depHi_reg <= {4'h0, regWrData[3:0]};
			if (wrLog) logCtl_reg <= regWrData[1:0];
			if (wrSw) swDis_reg <= regWrData[SWEN_BIT];
			if (wrRec) recov_reg <= regWrData;
			hwEnD_reg <= hwEnable;
		end
	end
	assign rdData_next = (regAddr == ADDR_LOG0)   ? log0_reg :
	                     (regAddr == ADDR_RSTCFG) ? rstCfg_reg :
	                     (regAddr == ADDR_DEPLO)  ? depLo_reg :
	                     (regAddr == ADDR_DEPHI)  ? depHi_reg :
	                     (regAddr == ADDR_LOGCTL) ? {6'h00, logCtl_reg} :
	                     (regAddr == ADDR_SWEN)   ? {7'h00, swDis_reg} :
	                     (regAddr == ADDR_RECOV)  ? recov_reg : 8'h00;
	// ****************************************
	// field decode
	// ****************************************
	wire [1:0]  condCode  = rstCfg_reg[RC_COND_LSB +: 2];
	wire        polHigh   = rstCfg_reg[RC_POL_BIT];
	wire        odMode    = rstCfg_reg[RC_OD_BIT];
	wire        latchMode = recov_reg[RV_LATCH_BIT];
	wire [1:0]  slewCode  = recov_reg[RV_SLEW_LSB +: 2];
	wire [4:0]  need      = 5'h02 << recov_reg[RV_DEG_LSB +: 2];
	wire        logOn     = logCtl_reg != LOG_NONE;
	wire [19:0] retryTicks = 20'(RETRY_US[recov_reg[RV_DLY_LSB +: 3]] * 1000 / TICK_NS);
	wire [19:0] rstTicks   = 20'(RSTTMO_US[rstCfg_reg[RC_TMO_LSB +: 3]] * 1000 / TICK_NS);
	wire [11:0] depAll     = {depHi_reg[3:0], depLo_reg};
	// ****************************************
	// timebase
	// ****************************************
	logic [15:0] pre_reg;
	wire         tick = pre_reg == 16'(TICK_CYC - 1);
	always_ff @(posedge ref_clk) begin
		if (!rstn) pre_reg <= 16'h0000;
		else pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
	end
	// ****************************************
	// deglitch per input
	// ****************************************
	wire [NUM_MON-1:0] condRaw = (condCode == COND_UV)   ? monUnder :
	                             (condCode == COND_WARN) ? monWarn :
	                             (condCode == COND_OV)   ? monOver : (monUnder | monOver);
	wire [NUM_MON-1:0] critRaw = (monUnder | monOver) & monCritEn;
	wire [NUM_MON-1:0] selMask = depAll[NUM_MON-1:0] | monCritEn;
	logic [NUM_MON-1:0] condDeb, critDeb;
	for (genvar gi = 0; gi < NUM_MON; gi++) begin : g_mon
		logic [4:0] cCnt_reg, kCnt_reg;
		always_ff @(posedge ref_clk) begin
			if (!rstn) begin
				cCnt_reg <= 5'h00;
				kCnt_reg <= 5'h00;
			end else if (convDone) begin
				cCnt_reg <= !condRaw[gi] ? 5'h00 : (cCnt_reg >= need) ? cCnt_reg : cCnt_reg + 5'h01;
				kCnt_reg <= !critRaw[gi] ? 5'h00 : (kCnt_reg >= need) ? kCnt_reg : kCnt_reg + 5'h01;
			end
		end
		assign condDeb[gi] = cCnt_reg >= need;
		assign critDeb[gi] = kCnt_reg >= need;
	end
	// ****************************************
	// sequencing control
	// ****************************************
	frr_state_t  state_reg, state_next;
	logic [19:0] timer_reg, timer_next;
	logic        latched_reg, latched_next, rstAssert_reg, rstAssert_next;
	wire active     = state_reg inside {FRR_SEQUP, FRR_RSTDLY, FRR_RUN};
	wire timerZero  = timer_reg == 20'h00000;
	wire seqFaultEv = active && seqFault;
	wire trackEv    = active && |(trackFault & trackLoopEn);
	wire shutdown   = seqFaultEv || trackEv || (active && |critDeb);
	wire latchClr   = (hwEnable && !hwEnD_reg) || (wrSw && !regWrData[SWEN_BIT]);
	wire runOk      = hwEnable && !swDis_reg && !latched_reg;
	wire mrActive   = mrSelect && !generalPinFour;
	wire rstCond    = |(condDeb & selMask) || mrActive;
	wire slot12Any  = |slot12Assign;
	wire pwrDone    = slot12Any ? &(~monUnder | ~slot12Assign) : slot12DelayDone;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			FRR_IDLE: if (runOk) state_next = FRR_SEQUP;
			FRR_SEQUP, FRR_RSTDLY, FRR_RUN: begin
				if (shutdown) state_next = latchMode ? FRR_LATCH : FRR_RETRY;
				else if (!runOk) state_next = FRR_IDLE;
				else if (state_reg == FRR_SEQUP && pwrDone) state_next = FRR_RSTDLY;
				else if (state_reg == FRR_RSTDLY && timerZero && !rstCond) state_next = FRR_RUN;
				else if (state_reg == FRR_RUN && rstCond) state_next = FRR_RSTDLY;
			end
			FRR_RETRY: if (timerZero) state_next = FRR_IDLE;
			FRR_LATCH: if (!latched_reg) state_next = FRR_IDLE;
		endcase
	end
	wire loadRetry = state_next == FRR_RETRY && state_reg != FRR_RETRY;
	wire loadRst   = state_next == FRR_RSTDLY && (state_reg != FRR_RSTDLY || rstCond);
	assign timer_next = loadRetry ? retryTicks : loadRst ? rstTicks :
	                    (tick && !timerZero) ? timer_reg - 20'h00001 : timer_reg;
	assign latched_next = (shutdown && latchMode) ? 1'b1 : latchClr ? 1'b0 : latched_reg;
	assign rstAssert_next = state_next != FRR_RUN || mrActive;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_reg     <= FRR_IDLE;
			timer_reg     <= 20'h00000;
			latched_reg   <= 1'b0;
			rstAssert_reg <= 1'b1;
		end else begin
			state_reg     <= state_next;
			timer_reg     <= timer_next;
			latched_reg   <= latched_next;
			rstAssert_reg <= rstAssert_next;
		end
	end
	// ****************************************
	// fault log byte zero
	// ****************************************
	always_comb begin
		log0_next = log0_reg;
		if (seqFaultEv && logOn) log0_next[3:0] = seqSlot;
		if (trackEv && logOn) begin
			log0_next[LOG_TRK_LSB +: 4] = log0_reg[LOG_TRK_LSB +: 4] & ~(trackFault & trackLoopEn);
		end
	end
	// ****************************************
	// tracking ramp
	// ****************************************
	logic [7:0] ramp_reg;
	wire  [7:0] rampPeriod = 8'(RAMP_BASE_TICKS) << slewCode;
	wire        rampWrap   = tick && ramp_reg == rampPeriod - 8'h01;
	// ****************************************
	// outputs
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ramp_reg      <= 8'h00;
			trackRampStep <= 1'b0;
			log0_reg      <= RST_LOG0;
			logStart      <= 1'b0;
			regRdData     <= 8'h00;
			enableGate    <= 1'b0;
			latchedOff    <= 1'b0;
			resetPinOut   <= 1'b0;
			resetPinOe    <= 1'b1;
		end else begin
			ramp_reg      <= rampWrap ? 8'h00 : tick ? ramp_reg + 8'h01 : ramp_reg;
			trackRampStep <= rampWrap;
			log0_reg      <= log0_next;
			logStart      <= (seqFaultEv || trackEv) && logOn;
			regRdData     <= rdData_next;
			enableGate    <= state_next inside {FRR_SEQUP, FRR_RSTDLY, FRR_RUN};
			latchedOff    <= latched_next;
			resetPinOut   <= rstAssert_next ~^ polHigh;
			resetPinOe    <= !odMode || rstAssert_next;
		end
	end
	assign logByteZero = log0_reg;
	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_seq_fault_drop: assert property (seqFault && active |=> !enableGate)
		else $error("enable not dropped on sequencing fault");
	a_slot_logged: assert property (seqFaultEv && logOn |=> log0_reg[3:0] == $past(seqSlot))
		else $error("failing slot not logged");
	a_track_cleared: assert property (trackEv && logOn
		|=> (log0_reg[7:4] & $past(trackFault & trackLoopEn)) == 4'h0)
		else $error("tracking log bit not cleared");
	a_retry_enter: assert property (shutdown && !latchMode |=> state_reg == FRR_RETRY
		&& timer_reg == $past(retryTicks))
		else $error("autoretry not started with selected delay");
	a_retry_restart: assert property (state_reg == FRR_RETRY && timerZero && runOk
		|=> ##1 state_reg == FRR_SEQUP)
		else $error("no restart after retry delay");
	a_latch_hold: assert property (latched_reg && !latchClr |=> latched_reg && !enableGate)
		else $error("latch-off left without clear");
	a_deglitch_min: assert property ($rose(critDeb[0]) |-> $past(convDone))
		else $error("fault counted without conversion");
	a_reset_hold: assert property (state_reg != FRR_RUN |-> rstAssert_reg)
		else $error("reset released outside normal operation");
	a_reset_timeout: assert property (state_reg == FRR_RSTDLY && !timerZero |=> state_reg != FRR_RUN)
		else $error("reset released before timeout");
	a_pin_level: assert property (##1 resetPinOut == (rstAssert_reg ~^ $past(polHigh)))
		else $error("reset polarity wrong");
	a_od_float: assert property ($past(odMode) && !rstAssert_reg |-> !resetPinOe)
		else $error("open-drain drives deasserted level");
	a_manual_rst: assert property (mrActive |=> rstAssert_reg)
		else $error("manual reset ignored");
	c_retry: cover property (state_reg == FRR_RETRY ##1 state_reg == FRR_IDLE);
	c_latch: cover property (state_reg == FRR_LATCH && latchClr);
	c_run: cover property (state_reg == FRR_RSTDLY ##1 state_reg == FRR_RUN);
	c_logged: cover property (logStart && trackEv);
endmodule : frr_fault_recovery

//--- hw/frr_pkg.sv
// constants, register map and state codes for the fault recovery and reset block
// assumes a 40 MHz clock and the documented 8-bit register offsets
package frr_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] ADDR_LOG0   = 8'h00;
	localparam logic [7:0] ADDR_RSTCFG = 8'h19;
	localparam logic [7:0] ADDR_DEPLO  = 8'h1a;
	localparam logic [7:0] ADDR_DEPHI  = 8'h1b;
	localparam logic [7:0] ADDR_LOGCTL = 8'h47;
	localparam logic [7:0] ADDR_SWEN   = 8'h4d;
	localparam logic [7:0] ADDR_RECOV  = 8'h4f;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_RSTCFG = 8'h00;
	localparam logic [7:0] RST_DEP    = 8'h00;
	localparam logic [1:0] RST_LOGCTL = 2'h0;
	localparam logic       RST_SWDIS  = 1'b1;
	localparam logic [7:0] RST_RECOV  = 8'h00;
	localparam logic [7:0] RST_LOG0   = 8'hff;
	// ****************************************
	// field positions
	// ****************************************
	localparam int RC_COND_LSB  = 0;
	localparam int RC_POL_BIT   = 2;
	localparam int RC_OD_BIT    = 3;
	localparam int RC_TMO_LSB   = 4;
	localparam int RV_DLY_LSB   = 0;
	localparam int RV_LATCH_BIT = 3;
	localparam int RV_SLEW_LSB  = 4;
	localparam int RV_DEG_LSB   = 6;
	localparam int SWEN_BIT     = 0;
	localparam int LOG_TRK_LSB  = 4;
	// ****************************************
	// codes and timing
	// ****************************************
	localparam logic [1:0] LOG_NONE  = 2'h3;
	localparam logic [1:0] COND_UV   = 2'h0;
	localparam logic [1:0] COND_WARN = 2'h1;
	localparam logic [1:0] COND_OV   = 2'h2;
	localparam int CLK_PERIOD_NS   = 25;
	localparam int TICK_NS         = 2500;
	localparam int RAMP_BASE_TICKS = 5;
	localparam int RETRY_US [8] = '{20, 12500, 25000, 50000, 100000, 200000, 400000, 1600000};
	localparam int RSTTMO_US [8] = '{25, 2000, 25000, 100000, 200000, 400000, 800000, 1600000};
	typedef enum logic [2:0] {
		FRR_IDLE   = 3'b000,
		FRR_SEQUP  = 3'b001,
		FRR_RSTDLY = 3'b011,
		FRR_RUN    = 3'b010,
		FRR_RETRY  = 3'b110,
		FRR_LATCH  = 3'b111
	} frr_state_t;
endpackage : frr_pkg

//--- verification/frr_partner_model.sv
// model of the supply switches and the host reset input
// assumes enableGate gates every supply and a pull-up sits on the reset net
`timescale 1ns/1ps
module frr_partner_model #(
	parameter int NUM_MON  = 12,
	parameter int RAMP_CYC = 6
) (
	input  wire logic               ref_clk,
	input  wire logic               enableGate,
	input  wire logic               resetPinOut,
	input  wire logic               resetPinOe,
	output logic      [NUM_MON-1:0] railLow,
	output logic                    resetLine
);
	// ****************************************
	// rails and reset net
	// ****************************************
	int rampCnt = 0;
	always @(posedge ref_clk) begin
		if (!enableGate)
			rampCnt <= 0;
		else if (rampCnt < RAMP_CYC)
			rampCnt <= rampCnt + 1;
	end
	// rails stay below threshold until the ramp is over
	assign railLow   = (rampCnt < RAMP_CYC) ? '1 : '0;
	assign resetLine = resetPinOe ? resetPinOut : 1'b1;
endmodule : frr_partner_model

//--- verification/testbench.sv
// self-checking bench for the fault recovery and reset block
// assumes frr_pkg and the design compiled first; tick shortened to one clock
`timescale 1ns/1ps
module testbench import frr_pkg::*;;
	`define CHECK(a, e) begin comparisons++; if ((a) !== (e)) begin numErrors++; \
		$display("unexpected at %0t: got %h want %h", $time, a, e); end end
	// ****************************************
	// signals and instances
	// ****************************************
	typedef struct packed {logic [1:0] cond; logic uv, ov, wn, asrt;} frr_row_t;
	frr_row_t rows [7] = '{'{2'h0, 1, 0, 0, 1}, '{2'h0, 0, 1, 0, 0}, '{2'h1, 0, 0, 1, 1},
		'{2'h2, 0, 1, 0, 1}, '{2'h2, 1, 0, 0, 0}, '{2'h3, 1, 0, 0, 1}, '{2'h3, 0, 1, 0, 1}};
	logic [15:0] regs [8] = '{16'h1900, 16'h1a00, 16'h1b00, 16'h4700, 16'h4d01, 16'h4f00,
		16'h00ff, 16'h2000};
	logic [23:0] rw [3] = '{24'h1bff0f, 24'h47ff03, 24'h0000ff};
	logic        ref_clk = 0, rstn = 0, regWrEn = 0, hwEnable = 1, convDone = 0;
	logic        slot12DelayDone = 0, seqFault = 0, mrSelect = 0, generalPinFour = 1;
	logic [7:0]  regAddr = 0, regWrData = 0, regRdData, logByteZero;
	logic [11:0] uvInj = 0, monOver = 0, monWarn = 0, monCritEn = 0, monUnder, railLow;
	logic [11:0] slot12Assign = 12'h001;
	logic [3:0]  seqSlot = 0, trackFault = 0, trackLoopEn = 0;
	logic        enableGate, latchedOff, resetPinOut, resetPinOe, logStart, resetLine;
	logic        trackRampStep;
	int          numErrors = 0, comparisons = 0, cycles = 0;
	assign monUnder = railLow | uvInj;
	always #12.5 ref_clk = ~ref_clk;
	frr_fault_recovery #(.TICK_CYC(1)) dut (.ref_clk, .rstn, .regWrEn, .regAddr, .regWrData,
		.regRdData, .hwEnable, .monUnder, .monOver, .monWarn, .convDone, .monCritEn,
		.slot12Assign, .slot12DelayDone, .seqFault, .seqSlot, .trackFault, .trackLoopEn,
		.mrSelect, .generalPinFour, .enableGate, .latchedOff, .resetPinOut, .resetPinOe,
		.logStart, .logByteZero, .trackRampStep);
	frr_partner_model partner (.ref_clk, .enableGate, .resetPinOut, .resetPinOe, .railLow,
		.resetLine);
	// ****************************************
	// tasks
	// ****************************************
	task automatic finishTest();
		$display("comparisons %0d mismatches %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finishTest
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			finishTest();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrEn   <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrEn   <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge ref_clk);
		regAddr <= a;
		@(posedge ref_clk);
		@(negedge ref_clk);
		q = regRdData;
	endtask : rd
	task automatic conv(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			convDone <= 1'b1;
			@(posedge ref_clk);
			convDone <= 1'b0;
		end
		repeat (3) @(negedge ref_clk);
	endtask : conv
	task automatic waitRst(input logic lvl);
		for (int i = 0; i < 200 && resetPinOut !== lvl; i++) @(negedge ref_clk);
		`CHECK(resetPinOut, lvl)
	endtask : waitRst
	task automatic fault(input logic [3:0] slot, input logic [3:0] trk);
		@(posedge ref_clk);
		seqFault   <= (trk == 4'h0);
		seqSlot    <= slot;
		trackFault <= trk;
		@(posedge ref_clk);
		seqFault   <= 1'b0;
		trackFault <= 4'h0;
		@(negedge ref_clk);
	endtask : fault
	task automatic powerUp();
		wr(ADDR_SWEN, 8'h00);
		for (int i = 0; i < 4 && enableGate !== 1'b1; i++) @(negedge ref_clk);
		`CHECK(enableGate, 1'b1)
		repeat (8) @(negedge ref_clk);
		`CHECK(resetPinOut, 1'b0)
		waitRst(1'b1);
		$display("test power-up done");
	endtask : powerUp
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [7:0] q;
		int         n;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		powerUp();
		wr(ADDR_DEPLO, 8'h01);
		foreach (rows[r]) begin
			wr(ADDR_RSTCFG, {6'h0, rows[r].cond});
			@(posedge ref_clk);
			uvInj   <= {11'h0, rows[r].uv};
			monOver <= {11'h0, rows[r].ov};
			monWarn <= {11'h0, rows[r].wn};
			conv(2);
			`CHECK(resetPinOut, ~rows[r].asrt)
			`CHECK(enableGate, 1'b1)
			@(posedge ref_clk);
			uvInj   <= '0;
			monOver <= '0;
			monWarn <= '0;
			conv(2);
			waitRst(1'b1);
		end
		$display("test condition rows done");
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		@(negedge ref_clk);
		`CHECK(enableGate, 1'b0)
		`CHECK(resetPinOut, 1'b0)
		`CHECK(resetPinOe, 1'b1)
		`CHECK(logByteZero, RST_LOG0)
		foreach (regs[k]) begin
			rd(regs[k][15:8], q);
			`CHECK(q, regs[k][7:0])
		end
		foreach (rw[k]) begin
			wr(rw[k][23:16], rw[k][15:8]);
			rd(rw[k][23:16], q);
			`CHECK(q, rw[k][7:0])
		end
		wr(ADDR_LOGCTL, 8'h00);
		wr(ADDR_DEPHI, 8'h00);
		$display("test reset values done");
		@(posedge ref_clk);
		slot12Assign    <= '0;
		slot12DelayDone <= 1'b1;
		powerUp();
		fault(4'h5, 4'h0);
		`CHECK(enableGate, 1'b0)
		`CHECK(logStart, 1'b1)
		`CHECK(logByteZero, 8'hf5)
		repeat (6) @(negedge ref_clk);
		`CHECK(enableGate, 1'b0)
		for (int i = 0; i < 10 && enableGate !== 1'b1; i++) @(negedge ref_clk);
		`CHECK(enableGate, 1'b1)
		waitRst(1'b1);
		wr(ADDR_LOGCTL, {6'h0, LOG_NONE});
		fault(4'h9, 4'h0);
		`CHECK(enableGate, 1'b0)
		`CHECK(logStart, 1'b0)
		`CHECK(logByteZero, 8'hf5)
		waitRst(1'b1);
		wr(ADDR_LOGCTL, 8'h00);
		@(posedge ref_clk);
		trackLoopEn <= 4'h5;
		fault(4'h0, 4'h6);
		`CHECK(logStart, 1'b1)
		`CHECK(logByteZero, 8'hb5)
		waitRst(1'b1);
		$display("test sequencing faults done");
		wr(ADDR_DEPLO, 8'h01);
		wr(ADDR_RECOV, 8'h40);
		@(posedge ref_clk);
		uvInj <= 12'h001;
		conv(3);
		`CHECK(resetPinOut, 1'b1)
		conv(1);
		`CHECK(resetPinOut, 1'b0)
		@(posedge ref_clk);
		uvInj <= '0;
		conv(4);
		waitRst(1'b1);
		wr(ADDR_RECOV, 8'h00);
		wr(ADDR_DEPLO, 8'h00);
		wr(ADDR_RSTCFG, 8'h01);
		@(posedge ref_clk);
		monCritEn <= 12'h002;
		monWarn   <= 12'h002;
		conv(2);
		`CHECK(resetPinOut, 1'b0)
		`CHECK(enableGate, 1'b1)
		@(posedge ref_clk);
		monCritEn <= 12'h001;
		monWarn   <= '0;
		uvInj     <= 12'h001;
		conv(2);
		`CHECK(enableGate, 1'b0)
		`CHECK(resetPinOut, 1'b0)
		@(posedge ref_clk);
		monCritEn <= '0;
		uvInj     <= '0;
		conv(2);
		waitRst(1'b1);
		$display("test deglitch and critical done");
		wr(ADDR_RECOV, 8'h08);
		fault(4'h3, 4'h0);
		`CHECK(latchedOff, 1'b1)
		repeat (30) @(negedge ref_clk);
		`CHECK(enableGate, 1'b0)
		wr(ADDR_SWEN, 8'h00);
		repeat (2) @(negedge ref_clk);
		`CHECK(latchedOff, 1'b0)
		waitRst(1'b1);
		fault(4'h3, 4'h0);
		@(posedge ref_clk);
		hwEnable <= 1'b0;
		repeat (4) @(negedge ref_clk);
		`CHECK(latchedOff, 1'b1)
		@(posedge ref_clk);
		hwEnable <= 1'b1;
		repeat (2) @(negedge ref_clk);
		`CHECK(latchedOff, 1'b0)
		waitRst(1'b1);
		wr(ADDR_RECOV, 8'h00);
		$display("test latch-off done");
		wr(ADDR_RSTCFG, 8'h0c);
		repeat (2) @(negedge ref_clk);
		`CHECK(resetPinOe, 1'b0)
		`CHECK(resetLine, 1'b1)
		@(posedge ref_clk);
		mrSelect       <= 1'b1;
		generalPinFour <= 1'b0;
		repeat (2) @(negedge ref_clk);
		`CHECK(resetPinOut, 1'b1)
		`CHECK(resetPinOe, 1'b1)
		@(posedge ref_clk);
		generalPinFour <= 1'b1;
		repeat (6) @(negedge ref_clk);
		`CHECK(resetPinOe, 1'b1)
		for (int i = 0; i < 40 && resetPinOe !== 1'b0; i++) @(negedge ref_clk);
		`CHECK(resetPinOe, 1'b0)
		wr(ADDR_RSTCFG, 8'h04);
		repeat (2) @(negedge ref_clk);
		`CHECK(resetPinOe, 1'b1)
		`CHECK(resetPinOut, 1'b0)
		wr(ADDR_RECOV, 8'h10);
		@(negedge ref_clk);
		for (int i = 0; i < 300 && trackRampStep !== 1'b1; i++) @(negedge ref_clk);
		n = 1;
		@(negedge ref_clk);
		for (int i = 0; i < 300 && trackRampStep !== 1'b1; i++) begin
			n++;
			@(negedge ref_clk);
		end
		`CHECK(n, RAMP_BASE_TICKS << 1)
		$display("test reset output done");
		finishTest();
	end
endmodule : testbench
